// ==== dv/acj_analog_src.sv ====
// Pin voltages in 1/128 supply steps feeding the comparator.
// An unselected comparator input floats, so its output wanders.
`timescale 1ns/1ps
module acj_analog_src (
   input wire logic i_clk,
   input wire logic [47:0] i_lvl,
   input wire logic [5:0] i_ref_code,
   input wire logic [5:0] i_pin_sel,
   output logic o_cmp_above
);
   logic [7:0] v;
   logic wander = 1'b0;
   always @(posedge i_clk) wander <= ~wander;
   always_comb begin
      v = 8'h00;
      for (int p = 0; p < 6; p++) begin
         if (i_pin_sel[p]) v = i_lvl[p*8 +: 8];
      end
      // Code n stands at (2n-1)/128 for n from 1 up; code 0 stands at 0
      o_cmp_above = v > {1'b0, i_ref_code, 1'b0} - 8'h01;
      if (i_ref_code == 6'h00) o_cmp_above = v > 8'h00;
      if (i_pin_sel == 6'h00) o_cmp_above = wander;
   end
endmodule

// ==== dv/acj_monitor.sv ====
// Checker on the compare judge ports.
// Assumes the judge address is held while a comparison runs.
`timescale 1ns/1ps
module acj_monitor (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire acj_pkg::acj_req_s i_req,
   input wire logic i_cmp_above,
   input wire logic [3:0] o_rdata,
   input wire logic o_busy,
   input wire logic [5:0] o_ref_code,
   input wire logic [5:0] o_pin_sel,
   input wire logic o_sw_ref,
   input wire logic o_sw_input
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   wire logic j = i_req.addr == acj_pkg::ADDR_JUDGE;
   wire logic [2:0] c = i_req.wdata[2:0];
   // Judge flag is undefined until a first comparison has run
   logic done_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         done_q <= 1'b0;
      end else if (o_busy) begin
         done_q <= 1'b1;
      end
   end
   a_rd_start: assert property (
      j && i_req.rd && !o_busy |=> o_busy) else $error("no start");
   a_one_instr: assert property (
      $rose(o_busy) |-> o_busy[*8] ##[1:880] !o_busy) else $error("long");
   a_upper_zero: assert property (
      j |-> o_rdata[3:1] == 3'h0) else $error("upper bits");
   a_unmapped_zero: assert property (
      i_req.addr == 7'h30 |-> o_rdata == 4'h0) else $error("unmapped");
   a_code_load: assert property (
      i_req.wr && i_req.addr == acj_pkg::ADDR_CODE |=>
      o_ref_code == $past(i_req.wdata[5:0])) else $error("code");
   a_pin_map: assert property (
      i_req.wr && i_req.addr == acj_pkg::ADDR_CHAN |=> o_pin_sel ==
      ($past(c) < 3'h6 ? 6'h01 << $past(c) : 6'h00)) else $error("pin");
   a_flag_take: assert property (
      j && $fell(o_busy) |-> o_rdata[0] == $past(i_cmp_above))
      else $error("flag");
   a_flag_hold: assert property (
      done_q && j && !o_busy && $past(j && !o_busy && done_q) |->
      $stable(o_rdata[0])) else $error("hold");
   a_ref_power: assert property (
      o_sw_ref == o_busy) else $error("ladder switch");
   a_input_sample: assert property (
      o_sw_input |-> o_busy && o_sw_ref) else $error("input switch");
   cover property ($fell(o_busy) && o_rdata[0]);
   cover property ($fell(o_busy) && !o_rdata[0]);
   cover property (o_pin_sel == 6'h00 && i_req.wr);
endmodule
bind acj_compare_judge acj_monitor i_mon (.i_clk, .i_arst_n, .i_req,
   .i_cmp_above, .o_rdata, .o_busy, .o_ref_code, .o_pin_sel, .o_sw_ref,
   .o_sw_input);

// ==== dv/testbench.sv ====
// Bench for the compare judge block with the pin voltage model.
`timescale 1ns/1ps
module testbench;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic soft_reset = 1'b0;
   acj_pkg::acj_req_s req = '0;
   logic [47:0] lvl = '0;
   logic cmp, busy;
   logic [3:0] rd;
   logic [5:0] code, sel;
   int err_count = 0;
   int checked = 0;
   int cl[3] = '{1, 32, 63};
   always #2.5 i_clk = ~i_clk;
   acj_compare_judge i_dut (.i_clk, .i_arst_n, .i_soft_reset(soft_reset),
      .i_req(req), .i_cmp_above(cmp), .o_rdata(rd), .o_busy(busy),
      .o_ref_code(code), .o_pin_sel(sel), .o_sw_ref(), .o_sw_input());
   acj_analog_src i_src (.i_clk, .i_lvl(lvl), .i_ref_code(code),
      .i_pin_sel(sel), .o_cmp_above(cmp));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic put(input logic [6:0] a, input logic [7:0] d);
      @(negedge i_clk);
      req = '{a, 1'b0, 1'b1, d};
      @(negedge i_clk);
      req.wr = 1'b0;
   endtask
   // Holds the judge address so the finished flag can be read
   task automatic judge(input logic e);
      int n = 0;
      put(acj_pkg::ADDR_JUDGE, 8'h00);
      req.rd = 1'b1;
      @(negedge i_clk);
      req.rd = 1'b0;
      while (busy === 1'b1 && n < 1000) begin
         @(negedge i_clk);
         n++;
      end
      chk({4'h0, rd}, {7'h00, e});
   endtask
   task automatic t_ladder;
      put(acj_pkg::ADDR_CHAN, 8'h00);
      foreach (cl[i]) begin
         put(acj_pkg::ADDR_CODE, 8'hC0 | 8'(cl[i]));
         lvl[7:0] = 8'(2 * cl[i]);
         judge(1'b1);
         lvl[7:0] = 8'(2 * cl[i] - 2);
         judge(1'b0);
      end
      $display("ladder done");
   endtask
   task automatic t_chan;
      lvl = 48'hFF << 32;
      put(acj_pkg::ADDR_CHAN, 8'h04);
      judge(1'b1);
      put(acj_pkg::ADDR_CHAN, 8'h03);
      judge(1'b0);
      put(acj_pkg::ADDR_CHAN, 8'h06);
      chk({2'h0, sel}, 8'h00);
      $display("channel done");
   endtask
   task automatic t_hold;
      lvl[47:40] = 8'hFF;
      put(acj_pkg::ADDR_CHAN, 8'h05);
      judge(1'b1);
      lvl = '0;
      soft_reset = 1'b1;
      repeat (3) @(negedge i_clk);
      soft_reset = 1'b0;
      chk({4'h0, rd}, 8'h01);
      judge(1'b0);
      req.addr = 7'h30;
      #1 chk({4'h0, rd}, 8'h00);
      $display("hold done");
   endtask
   task automatic give_verdict;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (4) @(negedge i_clk);
      i_arst_n = 1'b1;
      repeat (3) @(negedge i_clk);
      t_ladder();
      t_chan();
      t_hold();
      give_verdict();
   end
endmodule

// ==== rtl/acj_compare_judge.sv ====
// Compare judge control for a single-comparison converter.
// Assumes the analog comparator result arrives as a synchronous level and
// that the core issues one peripheral access per instruction time.
`timescale 1ns/1ps
module acj_compare_judge (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_soft_reset,
   input wire acj_pkg::acj_req_s i_req,
   input wire logic i_cmp_above,
   output logic [3:0] o_rdata,
   output logic o_busy,
   output logic [5:0] o_ref_code,
   output logic [5:0] o_pin_sel,
   output logic o_sw_ref,
   output logic o_sw_input
);
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_JUDGE} acj_state_e;
   localparam int unsigned CW = acj_pkg::CNT_W;
   localparam logic [CW-1:0] CNT_LAST = CW'(acj_pkg::SETTLE_CYCLES - 2);
   // Soft resets (clock stop, chip enable) leave every register as is

   // Address match on the seven-bit peripheral address
   function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
      hit = (a == b);
   endfunction

   // One-hot pin select; the two spare channel codes select no pin
   function automatic logic [5:0] pin_onehot(input logic [2:0] ch);
      pin_onehot = 6'h00;
      if (ch < 3'(acj_pkg::N_PINS)) begin
         pin_onehot[ch] = 1'b1;
      end
   endfunction

   // Read word per address; judge content only leaves through the flag bit
   function automatic logic [3:0] read_word(
      input logic [6:0] a,
      input logic [5:0] code,
      input logic [2:0] chan,
      input logic judge
   );
      read_word = 4'h0;
      if (hit(a, acj_pkg::ADDR_JUDGE)) begin
         read_word = {acj_pkg::JUDGE_UPPER_RESET, judge};
      end else if (hit(a, acj_pkg::ADDR_CODE)) begin
         read_word = code[3:0];
      end else if (hit(a, acj_pkg::ADDR_CHAN)) begin
         read_word = {1'b0, chan};
      end
   endfunction

   // Power-on reset release through two stages
   logic rst_s1_q;
   logic rst_s1_d;
   logic rst_n_q;
   logic rst_n_d;

   always_comb begin
      rst_s1_d = 1'b1;
      rst_n_d = rst_s1_q;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= rst_s1_d;
         rst_n_q <= rst_n_d;
      end
   end

   logic rd_judge;
   logic wr_code;
   logic wr_chan;

   assign rd_judge = i_req.rd && hit(i_req.addr, acj_pkg::ADDR_JUDGE);
   assign wr_code = i_req.wr && hit(i_req.addr, acj_pkg::ADDR_CODE);
   assign wr_chan = i_req.wr && hit(i_req.addr, acj_pkg::ADDR_CHAN);

   // Compare code register
   logic [5:0] code_q;
   logic [5:0] code_d;

   always_comb begin
      code_d = code_q;
      if (wr_code) begin
         code_d = i_req.wdata[5:0];
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         code_q <= 6'h00;
      end else begin
         code_q <= code_d;
      end
   end

   // Channel field and its registered pin select
   logic [2:0] chan_q;
   logic [2:0] chan_d;
   logic [5:0] pin_sel_q;
   logic [5:0] pin_sel_d;

   always_comb begin
      chan_d = chan_q;
      if (wr_chan) begin
         chan_d = i_req.wdata[2:0];
      end
      pin_sel_d = pin_onehot(chan_d);
   end

   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         chan_q <= acj_pkg::CHAN_RESET;
         pin_sel_q <= 6'h00;
      end else begin
         chan_q <= chan_d;
         pin_sel_q <= pin_sel_d;
      end
   end

   // Comparison sequence started by reading the judge register
   acj_state_e state_q;
   acj_state_e state_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (rd_judge) begin
               state_d = ST_SAMPLE;
               cnt_d = '0;
            end
         end
         ST_SAMPLE: begin
            cnt_d = cnt_q + CW'(1);
            if (cnt_q == CNT_LAST) begin
               state_d = ST_JUDGE;
            end
         end
         ST_JUDGE: begin
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Judge flop; reads while busy start nothing and leave it alone
   logic judge_q;
   logic judge_d;

   always_comb begin
      judge_d = judge_q;
      if (state_q == ST_JUDGE) begin
         judge_d = i_cmp_above;
      end
   end

   // Left unreset: its power-on value is undefined
   always_ff @(posedge i_clk) begin
      judge_q <= judge_d;
   end

   // Ladder is powered only during a comparison to save supply current
   logic sw_ref;
   logic sw_input;

   always_comb begin
      sw_ref = 1'b0;
      sw_input = 1'b0;
      case (state_q)
         ST_IDLE: begin
            sw_ref = 1'b0;
         end
         ST_SAMPLE: begin
            sw_ref = 1'b1;
            sw_input = 1'b1;
         end
         ST_JUDGE: begin
            sw_ref = 1'b1;
         end
         default: begin
            sw_ref = 1'b0;
            sw_input = 1'b0;
         end
      endcase
   end

   // Outputs
   assign o_busy = (state_q != ST_IDLE);
   assign o_sw_ref = sw_ref;
   assign o_sw_input = sw_input;
   assign o_ref_code = code_q;
   assign o_pin_sel = pin_sel_q;
   assign o_rdata = read_word(i_req.addr, code_q, chan_q, judge_q);
endmodule

// ==== rtl/acj_pkg.sv ====
// Package for the converter compare judge block: register addresses,
// field layouts, reset values and timing counts.
// Assumes a 200 MHz core clock and a 4-bit peripheral register port.
package acj_pkg;
   localparam int unsigned CLK_MHZ = 200;
   // One instruction time in nanoseconds
   localparam int unsigned INSTR_TIME_NS = 4440;
   localparam int unsigned INSTR_CYCLES = (INSTR_TIME_NS * CLK_MHZ) / 1000;
   // Comparator switches closed for settling before the judge is taken
   localparam int unsigned SETTLE_CYCLES = INSTR_CYCLES - 1;
   localparam logic [6:0] ADDR_CODE = 7'h02;
   localparam logic [6:0] ADDR_CHAN = 7'h14;
   localparam logic [6:0] ADDR_JUDGE = 7'h15;
   localparam int unsigned CODE_W = 6;
   localparam int unsigned CHAN_W = 3;
   localparam int unsigned N_PINS = 6;
   localparam logic [2:0] CHAN_RESET = 3'h7;
   localparam logic [2:0] JUDGE_UPPER_RESET = 3'h0;
   localparam int unsigned CNT_W = 12;
   typedef struct packed {
      logic [6:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } acj_req_s;
endpackage
